/* File: design/ipe_channel.sv */
/*
  One input channel: last error, weighted average error and current duration
  prediction, with software overwrite.
  Assumes calc strobes come from loop arithmetic on the same clock.
*/
`timescale 1ns/1ps
module ipe_channel
  import ipe_pkg::*;
#(
  parameter int VAL_W = IPE_VAL_W,
  parameter int AVG_SHIFT = IPE_AVG_SHIFT
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic incr_done,
  input wire logic signed [VAL_W-1:0] err_in,
  input wire logic synced_flag,
  input wire logic missing_evt,
  input wire logic predict_valid,
  input wire logic [VAL_W-1:0] predict_in,
  input wire logic wr_err,
  input wire logic wr_avg,
  input wire logic wr_pred,
  input wire logic [VAL_W-1:0] wr_val,
  output logic signed [VAL_W-1:0] err_last,
  output logic signed [VAL_W-1:0] err_avg,
  output logic [VAL_W-1:0] cur_predict,
  output logic skip_pending
);
  logic signed [VAL_W-1:0] err_next;
  logic signed [VAL_W-1:0] avg_next;
  logic [VAL_W-1:0] pred_next;
  logic skip_next;
  logic signed [VAL_W:0] diff;

  always_comb
  begin
    err_next = err_last;
    avg_next = err_avg;
    pred_next = cur_predict;
    skip_next = skip_pending;
    diff = {err_in[VAL_W-1], err_in} - {err_avg[VAL_W-1], err_avg};
    if (wr_err)
      err_next = wr_val;
    if (wr_avg)
      avg_next = wr_val;
    if (wr_pred)
      pred_next = wr_val;
    if (incr_done)
      err_next = err_in;
    if (missing_evt)
      skip_next = 1'b1;
    if (incr_done && synced_flag)
    begin
      // A miss on this very increment is the one skip, so nothing stays armed
      skip_next = 1'b0;
      if (!skip_pending && !missing_evt)
        avg_next = err_avg + VAL_W'(diff >>> AVG_SHIFT);
    end
    if (predict_valid)
      pred_next = predict_in;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      err_last <= IPE_VAL_RST;
      err_avg <= IPE_VAL_RST;
      cur_predict <= IPE_VAL_RST;
      skip_pending <= 1'b0;
    end
    else
    begin
      err_last <= err_next;
      err_avg <= avg_next;
      cur_predict <= pred_next;
      skip_pending <= skip_next;
    end
  end
endmodule : ipe_channel

/* File: design/ipe_store.sv */
/*
  Result word store for trigger and state inputs of the phase-locked loop,
  with a strobe register port.
  Assumes the loop arithmetic drives calc strobes and values on sys_clk.
*/
`timescale 1ns/1ps
module ipe_store
  import ipe_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [IPE_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic trig_incr_done,
  input wire logic [IPE_VAL_W-1:0] trig_err_in,
  input wire logic trig_synced_flag,
  input wire logic trig_missing_evt,
  input wire logic trig_predict_valid,
  input wire logic [IPE_VAL_W-1:0] trig_predict_in,
  input wire logic state_incr_done,
  input wire logic [IPE_VAL_W-1:0] state_err_in,
  input wire logic state_synced_flag,
  input wire logic state_missing_evt,
  input wire logic state_predict_valid,
  input wire logic [IPE_VAL_W-1:0] state_predict_in,
  output logic [IPE_VAL_W-1:0] trig_cur_predict,
  output logic [IPE_VAL_W-1:0] state_cur_predict
);
  logic [IPE_VAL_W-1:0] trig_err_last;
  logic [IPE_VAL_W-1:0] trig_err_avg;
  logic [IPE_VAL_W-1:0] trig_pred;
  logic [IPE_VAL_W-1:0] state_err_last;
  logic [IPE_VAL_W-1:0] state_err_avg;
  logic [IPE_VAL_W-1:0] state_pred;
  logic [IPE_VAL_W-1:0] wr_val;
  logic [31:0] rdata_next;
  logic [IPE_VAL_W-1:0] trig_pred_reg;
  logic [IPE_VAL_W-1:0] state_pred_reg;

  ////////////////////////////////////////////////////////////////////////////
  // reserved bits dropped
  assign wr_val = reg_wdata[IPE_FIELD_LSB +: IPE_VAL_W];

  ipe_channel u_trig (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .incr_done(trig_incr_done),
    .err_in(trig_err_in),
    .synced_flag(trig_synced_flag),
    .missing_evt(trig_missing_evt),
    .predict_valid(trig_predict_valid),
    .predict_in(trig_predict_in),
    .wr_err(reg_wr && reg_addr == IPE_TRIG_ERR_LAST_OFS),
    .wr_avg(reg_wr && reg_addr == IPE_TRIG_ERR_AVG_OFS),
    .wr_pred(reg_wr && reg_addr == IPE_TRIG_CUR_PREDICT_OFS),
    .wr_val(wr_val),
    .err_last(trig_err_last),
    .err_avg(trig_err_avg),
    .cur_predict(trig_pred),
    .skip_pending()
  );

  ipe_channel u_state (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .incr_done(state_incr_done),
    .err_in(state_err_in),
    .synced_flag(state_synced_flag),
    .missing_evt(state_missing_evt),
    .predict_valid(state_predict_valid),
    .predict_in(state_predict_in),
    .wr_err(reg_wr && reg_addr == IPE_STATE_ERR_LAST_OFS),
    .wr_avg(reg_wr && reg_addr == IPE_STATE_ERR_AVG_OFS),
    .wr_pred(reg_wr && reg_addr == IPE_STATE_CUR_PREDICT_OFS),
    .wr_val(wr_val),
    .err_last(state_err_last),
    .err_avg(state_err_avg),
    .cur_predict(state_pred),
    .skip_pending()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped words read zero
  always_comb
  begin
    rdata_next = IPE_RDATA_RST;
    if (reg_rd)
    begin
      unique case (reg_addr)
        IPE_TRIG_ERR_LAST_OFS: rdata_next = {trig_err_last, 8'h00};
        IPE_TRIG_ERR_AVG_OFS: rdata_next = {trig_err_avg, 8'h00};
        IPE_STATE_ERR_LAST_OFS: rdata_next = {state_err_last, 8'h00};
        IPE_STATE_ERR_AVG_OFS: rdata_next = {state_err_avg, 8'h00};
        IPE_TRIG_CUR_PREDICT_OFS: rdata_next = {trig_pred, 8'h00};
        IPE_STATE_CUR_PREDICT_OFS: rdata_next = {state_pred, 8'h00};
        default: rdata_next = IPE_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      reg_rdata <= IPE_RDATA_RST;
      trig_pred_reg <= IPE_VAL_RST;
      state_pred_reg <= IPE_VAL_RST;
    end
    else
    begin
      reg_rdata <= rdata_next;
      trig_pred_reg <= trig_pred;
      state_pred_reg <= state_pred;
    end
  end

  assign trig_cur_predict = trig_pred_reg;
  assign state_cur_predict = state_pred_reg;
endmodule : ipe_store

/* File: pkg/ipe_pkg.sv */
/*
  Package for the increment prediction error store: word byte offsets, field layout,
  reset values and the weighted-average shift.
  Assumes a plain strobe register port with 32-bit words and one-cycle read data.
*/
// Notes on behaviour
// - The trigger word keeps the signed 24-bit error of the last simple prediction in bits 8 to 31.
// - The trigger average word keeps a signed 24-bit weighted average of prediction errors.
// - The trigger average updates only while the trigger synced flag is one.
// - After an unexpected missing trigger event the trigger average skips exactly one update.
// - The state word keeps the signed 24-bit error of the last prediction in bits 8 to 31.
// - The state average word keeps a signed 24-bit weighted average of prediction errors.
// - The state average updates only while the state synced flag is one.
// - After an unexpected missing state event the state average skips exactly one update.
// - The computed trigger duration prediction goes into bits 8 to 31 of its word.
// - The computed state duration prediction goes into bits 8 to 31 of its word.
// - Bits 0 to 7 of every word read as zero and software writes zero there.
package ipe_pkg;
  localparam int IPE_ADDR_W = 5;
  localparam int IPE_VAL_W = 24;
  localparam int IPE_FIELD_LSB = 8;
  localparam logic [IPE_ADDR_W-1:0] IPE_TRIG_ERR_LAST_OFS = 5'h00;
  localparam logic [IPE_ADDR_W-1:0] IPE_TRIG_ERR_AVG_OFS = 5'h04;
  localparam logic [IPE_ADDR_W-1:0] IPE_STATE_ERR_LAST_OFS = 5'h08;
  localparam logic [IPE_ADDR_W-1:0] IPE_STATE_ERR_AVG_OFS = 5'h0C;
  localparam logic [IPE_ADDR_W-1:0] IPE_TRIG_CUR_PREDICT_OFS = 5'h10;
  localparam logic [IPE_ADDR_W-1:0] IPE_STATE_CUR_PREDICT_OFS = 5'h14;
  localparam logic [IPE_VAL_W-1:0] IPE_VAL_RST = 24'h00_0000;
  localparam logic [31:0] IPE_RDATA_RST = 32'h0000_0000;
  localparam int IPE_AVG_SHIFT = 3;
endpackage : ipe_pkg

/* File: sim/ipe_store_asserts.sv */
/* Port checker for ipe_store.
   Bound to every ipe_store instance; sees only its ports. */
`timescale 1ns/1ps
module ipe_store_asserts
  import ipe_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [IPE_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic trig_predict_valid,
  input wire logic [IPE_VAL_W-1:0] trig_predict_in,
  input wire logic state_predict_valid,
  input wire logic [IPE_VAL_W-1:0] state_predict_in,
  input wire logic [IPE_VAL_W-1:0] trig_cur_predict,
  input wire logic [IPE_VAL_W-1:0] state_cur_predict
);
  wire [23:0] wval = reg_wdata[31:8];
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  AST_RSV_ZERO: assert property (reg_rdata[7:0] == 8'h00) else $error("low byte set");
  AST_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  AST_TPRED: assert property (trig_predict_valid ##1 !reg_wr
    |-> ##1 trig_cur_predict == $past(trig_predict_in, 2)) else $error("trig predict lost");
  AST_SPRED: assert property (state_predict_valid ##1 !reg_wr
    |-> ##1 state_cur_predict == $past(state_predict_in, 2)) else $error("state predict lost");
  AST_TRD: assert property (reg_rd && reg_addr == IPE_TRIG_CUR_PREDICT_OFS
    |=> reg_rdata == {trig_cur_predict, 8'h00}) else $error("trig predict read");
  AST_SRD: assert property (reg_rd && reg_addr == IPE_STATE_CUR_PREDICT_OFS
    |=> reg_rdata == {state_cur_predict, 8'h00}) else $error("state predict read");
  AST_WRP: assert property (reg_wr && reg_addr == IPE_STATE_CUR_PREDICT_OFS
    && !state_predict_valid ##1 !reg_wr && !state_predict_valid
    |-> ##1 state_cur_predict == $past(wval, 2)) else $error("write not stored");
  AST_HOLD: assert property ((!trig_predict_valid && !reg_wr)[*2]
    |=> $stable(trig_cur_predict)) else $error("predict changed alone");
  cover property (trig_predict_valid);
  cover property (reg_wr && reg_addr == IPE_STATE_CUR_PREDICT_OFS);
  cover property (reg_rd && reg_addr == IPE_TRIG_CUR_PREDICT_OFS);
endmodule : ipe_store_asserts

bind ipe_store ipe_store_asserts u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .trig_predict_valid(trig_predict_valid), .trig_predict_in(trig_predict_in),
  .state_predict_valid(state_predict_valid), .state_predict_in(state_predict_in),
  .trig_cur_predict(trig_cur_predict), .state_cur_predict(state_cur_predict));

/* File: sim/ipe_store_test.sv */
/* Register-level bench for ipe_store.
   Both channels share stimulus; state values differ so swaps show. */
`timescale 1ns/1ps
module ipe_store_test
  import ipe_pkg::*;
;
  logic sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic done = 1'b0, sync = 1'b0, miss = 1'b0, pv = 1'b0, skp = 1'b0;
  logic [IPE_ADDR_W-1:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
  logic [23:0] err = 24'h00_0000, pred = 24'h00_0000, tl = 24'h00_0000;
  logic signed [23:0] ta = 24'h00_0000, sa = 24'h00_0000;
  logic [23:0] tcp, scp;
  int err_total = 0, check_count = 0;
  always #12.5 sys_clk = ~sys_clk;
  ipe_store dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_incr_done(done),
    .trig_err_in(err), .trig_synced_flag(sync), .trig_missing_evt(miss),
    .trig_predict_valid(pv), .trig_predict_in(pred), .state_incr_done(done),
    .state_err_in({err[22:0], 1'b0}), .state_synced_flag(sync), .state_missing_evt(miss),
    .state_predict_valid(pv), .state_predict_in(~pred), .trig_cur_predict(tcp),
    .state_cur_predict(scp));
  function automatic logic signed [23:0] avg_f(input logic signed [23:0] a, e);
    return a + ((e - a) >>> IPE_AVG_SHIFT);
  endfunction : avg_f
  task complete_run;
    if (err_total == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [4:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  task step(input logic d, input logic [23:0] e, input logic s, m);
    @(posedge sys_clk);
    {done, err, sync, miss} <= {d, e, s, m};
    @(posedge sys_clk);
    {done, miss} <= 2'b00;
    if (d) tl = e;
    if (d && s && (skp || m)) skp = 1'b0;
    else if (d && s) {ta, sa} = {avg_f(ta, e), avg_f(sa, {e[22:0], 1'b0})};
    else if (m) skp = 1'b1;
    rd(IPE_TRIG_ERR_LAST_OFS, {tl, 8'h00});
    rd(IPE_TRIG_ERR_AVG_OFS, {ta, 8'h00});
    rd(IPE_STATE_ERR_LAST_OFS, {tl[22:0], 1'b0, 8'h00});
    rd(IPE_STATE_ERR_AVG_OFS, {sa, 8'h00});
  endtask : step
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    step(1'b0, 24'h00_0000, 1'b0, 1'b0);
    step(1'b1, 24'h00_0100, 1'b0, 1'b0);
    step(1'b1, 24'hFF_FF00, 1'b1, 1'b0);
    step(1'b0, 24'h00_0000, 1'b1, 1'b1);
    step(1'b1, 24'h00_0400, 1'b1, 1'b0);
    step(1'b1, 24'h00_0400, 1'b1, 1'b0);
    wr(IPE_TRIG_ERR_AVG_OFS, 32'h0008_0000);
    ta = 24'h00_0800;
    step(1'b1, 24'h00_0000, 1'b1, 1'b0);
    step(1'b1, 24'h00_0040, 1'b1, 1'b1);
    step(1'b1, 24'h00_0040, 1'b1, 1'b0);
    @(posedge sys_clk);
    {pv, pred} <= {1'b1, 24'h12_3456};
    @(posedge sys_clk);
    pv <= 1'b0;
    rd(IPE_TRIG_CUR_PREDICT_OFS, 32'h1234_5600);
    rd(IPE_STATE_CUR_PREDICT_OFS, 32'hEDCB_A900);
    chk({8'h00, tcp}, 32'h0012_3456);
    chk({8'h00, scp}, 32'h00ED_CBA9);
    wr(IPE_STATE_CUR_PREDICT_OFS, 32'hABCD_EF00);
    rd(IPE_STATE_CUR_PREDICT_OFS, 32'hABCD_EF00);
    chk({8'h00, scp}, 32'h00AB_CDEF);
    wr(5'h18, 32'hFFFF_FF00);
    rd(5'h18, 32'h0000_0000);
    complete_run;
  end
endmodule : ipe_store_test
